// *** ssp_top.sv ***
// Contract
// - two low config bits pick pin function
// - answer only fixed address 0x2E, plus alert response address 0x0C while the alert is active
// - nine pulses per byte, msb first
// - data changes only while clock low
// - address byte fixes transfer direction
// - writes of one or two bytes, reads repeat the pointed byte while the host acks
// - first written byte loads address pointer
// - second written byte stores to pointed register
// - read returns register selected by pointer
// - send byte acks address, command sets pointer
// - write byte acks address, command, data
// - receive byte acks address, sends pointed byte
// - acknowledge only when addressed
// - repeated start accepted without stop
// - alert response read returns own address
// - arbitration on alert response, lowest wins
// - alert released only when cause gone; leaving alert pin mode clears it even with the cause present
// - idle bus mid-transfer times out to idle
// - config1 bit6 disables the timeout
`timescale 1ns/10ps
`include "ssp_cfg.svh"
module ssp_top #(
   parameter int TIMEOUT_CYC = `SSP_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   // bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output wire logic o_sda_out,
   output wire logic o_sda_oe,
   // multi-purpose pin
   input wire logic i_mp_pin,
   output wire logic o_mp_out,
   output wire logic o_mp_oe,
   // monitor side
   input wire logic i_alert_cond,
   input wire logic i_tlimit_assert,
   input wire logic i_gpio_value,
   input wire logic i_gpio_dir,
   output wire logic o_alert_active,
   output wire logic o_thermal_limit_pin,
   output wire logic o_fourth_tach_input,
   output wire logic o_gpio_in,
   // other registers of the device
   output wire logic [7:0] o_ptr,
   output wire logic o_ext_wr,
   output wire logic [7:0] o_ext_wdata,
   input wire logic [7:0] i_ext_rdata
);
   localparam logic [22:0] TO_M1 = 23'(TIMEOUT_CYC - 1);

   if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 8388607) begin : g_chk
      $error("TIMEOUT_CYC out of range");
   end

   ssp_link_if lk ();

   ssp_pkg::ssp_st_e st_reg;
   ssp_pkg::ssp_mp_e mode;
   logic scl_m_reg, scl_s_reg, scl_d_reg;
   logic sda_m_reg, sda_s_reg, sda_d_reg;
   logic mp_m_reg, mp_s_reg;
   logic bt_m_reg, bt_s_reg, bt_d_reg;
   logic ak_m_reg, ak_s_reg, ak_d_reg;
   logic clr_n_reg, sda_oe_reg, ack_pend_reg, ack_drv_reg, ara_reg, ara_done_reg;
   logic [7:0] tx_sh_reg, ptr_reg, wdat_reg, cfg1_reg, pincfg_reg, rd_data;
   logic [3:0] tx_cnt_reg;
   logic wr_stb_reg;
   logic [22:0] idle_cnt_reg;
   logic alert_reg, mp_oe_reg, tlim_in_reg, tach_reg, gpio_in_reg;
   logic start_det, stop_det, scl_fall, activity, byte_evt, ack_evt, timeout, lost_arb, ara_ok;

   ssp_link_rx u_link (
      .i_scl(i_scl),
      .i_sda(i_sda),
      .i_arst_n(i_arst_n),
      .lk(lk.link)
   );

   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   // pins and link toggles each pass two flops; edges compare the second stage with a third delay flop
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
         {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
         {mp_m_reg, mp_s_reg} <= 2'h3;
         {bt_m_reg, bt_s_reg, bt_d_reg} <= 3'h0;
         {ak_m_reg, ak_s_reg, ak_d_reg} <= 3'h0;
      end else begin
         {scl_m_reg, scl_s_reg, scl_d_reg} <= {i_scl, scl_m_reg, scl_s_reg};
         {sda_m_reg, sda_s_reg, sda_d_reg} <= {i_sda, sda_m_reg, sda_s_reg};
         {mp_m_reg, mp_s_reg} <= {i_mp_pin, mp_m_reg};
         {bt_m_reg, bt_s_reg, bt_d_reg} <= {lk.byte_tgl, bt_m_reg, bt_s_reg};
         {ak_m_reg, ak_s_reg, ak_d_reg} <= {lk.ack_tgl, ak_m_reg, ak_s_reg};
      end
   end

   // sda moving while scl is high marks start or stop
   assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
   assign stop_det = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
   assign scl_fall = scl_d_reg && !scl_s_reg;
   assign activity = (scl_s_reg ^ scl_d_reg) | (sda_s_reg ^ sda_d_reg);
   assign byte_evt = bt_s_reg ^ bt_d_reg;
   assign ack_evt = ak_s_reg ^ ak_d_reg;
   assign mode = ssp_pkg::ssp_mp_e'(pincfg_reg[`SSP_PINSEL_MSB:`SSP_PINSEL_LSB]);
   assign ara_ok = alert_reg && (mode == ssp_pkg::MP_ALERT);
   // a released one that reads back low means another sender won
   assign lost_arb = (st_reg == ssp_pkg::ST_TX) && scl_s_reg && !sda_oe_reg && !sda_s_reg && !ack_drv_reg
                     && !ack_pend_reg && (tx_cnt_reg != `SSP_TX_BITS);

   // ----------------------------------------
   // read data select
   // ----------------------------------------
   always_comb begin
      case (ptr_reg)
         `SSP_OFF_CFG1: rd_data = cfg1_reg;
         `SSP_OFF_PINCFG: rd_data = pincfg_reg;
         default: rd_data = i_ext_rdata;
      endcase
   end

   // ----------------------------------------
   // protocol engine
   // ----------------------------------------
   // sda is only ever changed on a seen scl fall or released by a start, stop or timeout, so the hold time is about three core cycles
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_reg <= ssp_pkg::ST_IDLE;
         clr_n_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         ack_pend_reg <= 1'b0;
         ack_drv_reg <= 1'b0;
         tx_sh_reg <= 8'h00;
         tx_cnt_reg <= 4'h0;
         ara_reg <= 1'b0;
         ara_done_reg <= 1'b0;
         ptr_reg <= 8'h00;
         wr_stb_reg <= 1'b0;
         wdat_reg <= 8'h00;
      end else begin
         wr_stb_reg <= 1'b0;
         ara_done_reg <= 1'b0;
         if (start_det) begin
            st_reg <= ssp_pkg::ST_ADDR;
            clr_n_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            ack_drv_reg <= 1'b0;
            ara_reg <= 1'b0;
         end else if (stop_det || timeout) begin
            st_reg <= ssp_pkg::ST_IDLE;
            clr_n_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            ack_drv_reg <= 1'b0;
            ara_reg <= 1'b0;
         end else begin
            // release the link framing once scl is low, well before its next rise
            if (st_reg != ssp_pkg::ST_IDLE && !scl_s_reg) begin
               clr_n_reg <= 1'b1;
            end
            if (byte_evt) begin
               case (st_reg)
                  ssp_pkg::ST_ADDR: begin
                     if (lk.rx_byte[7:1] == `SSP_OWN_ADDR) begin
                        ack_pend_reg <= 1'b1;
                        if (lk.rx_byte[0]) begin
                           st_reg <= ssp_pkg::ST_TX;
                           tx_sh_reg <= rd_data;
                           tx_cnt_reg <= `SSP_TX_BITS;
                        end else begin
                           st_reg <= ssp_pkg::ST_CMD;
                        end
                     end else if (lk.rx_byte == {`SSP_ARA_ADDR, 1'b1} && ara_ok) begin
                        ack_pend_reg <= 1'b1;
                        st_reg <= ssp_pkg::ST_TX;
                        tx_sh_reg <= {`SSP_OWN_ADDR, `SSP_ARA_LSB};
                        tx_cnt_reg <= `SSP_TX_BITS;
                        ara_reg <= 1'b1;
                     end else begin
                        st_reg <= ssp_pkg::ST_SKIP;
                     end
                  end
                  ssp_pkg::ST_CMD: begin
                     ptr_reg <= lk.rx_byte;
                     ack_pend_reg <= 1'b1;
                     st_reg <= ssp_pkg::ST_DATA;
                  end
                  ssp_pkg::ST_DATA: begin
                     wr_stb_reg <= 1'b1;
                     wdat_reg <= lk.rx_byte;
                     ack_pend_reg <= 1'b1;
                     st_reg <= ssp_pkg::ST_SKIP;
                  end
                  default: begin
                  end
               endcase
            end
            // master answer after our byte: nack ends it, ack gets the same byte again
            if (ack_evt && st_reg == ssp_pkg::ST_TXACK) begin
               if (lk.ack_bit) begin
                  st_reg <= ssp_pkg::ST_SKIP;
                  ara_done_reg <= ara_reg;
               end else begin
                  st_reg <= ssp_pkg::ST_TX;
                  tx_sh_reg <= ara_reg ? {`SSP_OWN_ADDR, `SSP_ARA_LSB} : rd_data;
                  tx_cnt_reg <= `SSP_TX_BITS;
               end
            end
            if (lost_arb) begin
               st_reg <= ssp_pkg::ST_SKIP;
            end
            if (scl_fall) begin
               if (ack_pend_reg) begin
                  sda_oe_reg <= 1'b1;
                  ack_pend_reg <= 1'b0;
                  ack_drv_reg <= 1'b1;
               end else if (ack_drv_reg) begin
                  ack_drv_reg <= 1'b0;
                  if (st_reg == ssp_pkg::ST_TX) begin
                     sda_oe_reg <= ~tx_sh_reg[7];
                     tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                     tx_cnt_reg <= tx_cnt_reg - 4'h1;
                  end else begin
                     sda_oe_reg <= 1'b0;
                  end
               end else if (st_reg == ssp_pkg::ST_TX) begin
                  if (tx_cnt_reg != 4'h0) begin
                     sda_oe_reg <= ~tx_sh_reg[7];
                     tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                     tx_cnt_reg <= tx_cnt_reg - 4'h1;
                  end else begin
                     sda_oe_reg <= 1'b0;
                     st_reg <= ssp_pkg::ST_TXACK;
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------
   // bus timeout
   // ----------------------------------------
   // any edge on either line restarts the count; idle bus is never timed; it clears as it fires so it fires once
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         idle_cnt_reg <= 23'h000000;
      end else if (st_reg == ssp_pkg::ST_IDLE || activity || timeout || cfg1_reg[`SSP_TIMEOUT_OFF_BIT]) begin
         idle_cnt_reg <= 23'h000000;
      end else if (idle_cnt_reg != TO_M1) begin
         idle_cnt_reg <= idle_cnt_reg + 23'h000001;
      end
   end
   assign timeout = (idle_cnt_reg == TO_M1);

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cfg1_reg <= `SSP_CFG1_RST;
         pincfg_reg <= `SSP_PINCFG_RST;
      end else if (wr_stb_reg) begin
         case (ptr_reg)
            `SSP_OFF_CFG1: cfg1_reg <= wdat_reg;
            `SSP_OFF_PINCFG: pincfg_reg <= wdat_reg;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // alert and multi-purpose pin
   // ----------------------------------------
   // a live cause keeps the alert even in the cycle the response completes
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         alert_reg <= 1'b0;
      end else if (mode != ssp_pkg::MP_ALERT) begin
         alert_reg <= 1'b0;
      end else if (i_alert_cond) begin
         alert_reg <= 1'b1;
      end else if (ara_done_reg) begin
         alert_reg <= 1'b0;
      end
   end

   // pin is open drain: enable means pull low; polarity of the gpio is handled outside
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mp_oe_reg <= 1'b0;
         tlim_in_reg <= 1'b0;
         tach_reg <= 1'b0;
         gpio_in_reg <= 1'b0;
      end else begin
         case (mode)
            ssp_pkg::MP_ALERT: mp_oe_reg <= alert_reg;
            ssp_pkg::MP_TLIMIT: mp_oe_reg <= i_tlimit_assert;
            ssp_pkg::MP_GPIO: mp_oe_reg <= i_gpio_dir && !i_gpio_value;
            default: mp_oe_reg <= 1'b0;
         endcase
         tlim_in_reg <= (mode == ssp_pkg::MP_TLIMIT) && !mp_s_reg;
         tach_reg <= (mode == ssp_pkg::MP_TACH) && mp_s_reg;
         gpio_in_reg <= (mode == ssp_pkg::MP_GPIO) && mp_s_reg;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign lk.frame_clr_n = clr_n_reg;
   assign o_sda_out = 1'b0;
   assign o_sda_oe = sda_oe_reg;
   assign o_mp_out = 1'b0;
   assign o_mp_oe = mp_oe_reg;
   assign o_alert_active = alert_reg;
   assign o_thermal_limit_pin = tlim_in_reg;
   assign o_fourth_tach_input = tach_reg;
   assign o_gpio_in = gpio_in_reg;
   assign o_ptr = ptr_reg;
   assign o_ext_wr = wr_stb_reg && ptr_reg != `SSP_OFF_CFG1 && ptr_reg != `SSP_OFF_PINCFG;
   assign o_ext_wdata = wdat_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);

   property p_sda_low_clk;
      $rose(sda_oe_reg) |-> !scl_s_reg;
   endproperty
   a_sda_low_clk: assert property (p_sda_low_clk) else $error("sda driven while scl high");

   property p_own_ack;
      byte_evt && st_reg == ssp_pkg::ST_ADDR && lk.rx_byte[7:1] == `SSP_OWN_ADDR |=> ack_pend_reg;
   endproperty
   a_own_ack: assert property (p_own_ack) else $error("own address not acked");

   property p_foreign;
      byte_evt && st_reg == ssp_pkg::ST_ADDR && lk.rx_byte[7:1] != `SSP_OWN_ADDR && lk.rx_byte[7:1] != `SSP_ARA_ADDR
      |=> st_reg == ssp_pkg::ST_SKIP && !ack_pend_reg ##1 !sda_oe_reg;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address acked");

   property p_ptr;
      byte_evt && st_reg == ssp_pkg::ST_CMD |=> ptr_reg == $past(lk.rx_byte) && st_reg == ssp_pkg::ST_DATA;
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer not loaded");

   property p_wdata;
      byte_evt && st_reg == ssp_pkg::ST_DATA |=> wr_stb_reg && wdat_reg == $past(lk.rx_byte) && st_reg == ssp_pkg::ST_SKIP;
   endproperty
   a_wdata: assert property (p_wdata) else $error("data byte not stored");

   property p_rd_load;
      byte_evt && st_reg == ssp_pkg::ST_ADDR && lk.rx_byte == {`SSP_OWN_ADDR, 1'b1} |=> tx_sh_reg == $past(rd_data);
   endproperty
   a_rd_load: assert property (p_rd_load) else $error("read data not from pointer");

   property p_ara_gate;
      byte_evt && st_reg == ssp_pkg::ST_ADDR && lk.rx_byte == {`SSP_ARA_ADDR, 1'b1} && !ara_ok |=> !ack_pend_reg;
   endproperty
   a_ara_gate: assert property (p_ara_gate) else $error("alert response without alert");

   property p_ara_addr;
      byte_evt && st_reg == ssp_pkg::ST_ADDR && lk.rx_byte == {`SSP_ARA_ADDR, 1'b1} && ara_ok
      |=> ack_pend_reg && tx_sh_reg == {`SSP_OWN_ADDR, `SSP_ARA_LSB};
   endproperty
   a_ara_addr: assert property (p_ara_addr) else $error("alert response wrong");

   property p_arb;
      lost_arb |=> st_reg == ssp_pkg::ST_SKIP && !sda_oe_reg;
   endproperty
   a_arb: assert property (p_arb) else $error("lost arbitration kept driving");

   property p_alert_hold;
      alert_reg && i_alert_cond && mode == ssp_pkg::MP_ALERT && $stable(pincfg_reg) |=> alert_reg;
   endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("alert dropped with cause present");

   property p_timeout;
      timeout && !start_det |=> st_reg == ssp_pkg::ST_IDLE && !sda_oe_reg && idle_cnt_reg == 23'h000000;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout did not release");

   property p_timeout_off;
      cfg1_reg[`SSP_TIMEOUT_OFF_BIT] |=> idle_cnt_reg == 23'h000000;
   endproperty
   a_timeout_off: assert property (p_timeout_off) else $error("timeout counted while disabled");

   property p_rstart;
      start_det |=> st_reg == ssp_pkg::ST_ADDR && !sda_oe_reg;
   endproperty
   a_rstart: assert property (p_rstart) else $error("start not taken");

   c_write: cover property (wr_stb_reg);
   c_read: cover property (ack_evt && st_reg == ssp_pkg::ST_TXACK && lk.ack_bit && !ara_reg);
   c_ara: cover property (ara_done_reg);
   c_timeout: cover property (timeout);
endmodule

// *** ssp_cfg.svh ***
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ----------------------------------------
// bus addresses
// ----------------------------------------
`define SSP_OWN_ADDR 7'h2e
`define SSP_ARA_ADDR 7'h0c
`define SSP_ARA_LSB 1'b0

// ----------------------------------------
// register offsets, fields, reset values
// ----------------------------------------
`define SSP_OFF_CFG1 8'h40
`define SSP_OFF_PINCFG 8'h7d
`define SSP_TIMEOUT_OFF_BIT 6
`define SSP_PINSEL_LSB 0
`define SSP_PINSEL_MSB 1
`define SSP_CFG1_RST 8'h00
`define SSP_PINCFG_RST 8'h00

// ----------------------------------------
// framing and timing
// ----------------------------------------
`define SSP_LAST_DATA_BIT 4'h7
`define SSP_ACK_BIT 4'h8
`define SSP_TX_BITS 4'h8
`define SSP_TIMEOUT_MS 35
`define SSP_CORE_KHZ 200000
`define SSP_TIMEOUT_CYC (`SSP_TIMEOUT_MS * `SSP_CORE_KHZ)

`endif

// *** ssp_pkg.sv ***
package ssp_pkg;
   // one-hot protocol states
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_ADDR  = 7'h02,
      ST_CMD   = 7'h04,
      ST_DATA  = 7'h08,
      ST_TX    = 7'h10,
      ST_TXACK = 7'h20,
      ST_SKIP  = 7'h40
   } ssp_st_e;

   // multi-purpose pin function select
   typedef enum logic [1:0] {
      MP_ALERT = 2'h0,
      MP_TLIMIT = 2'h1,
      MP_GPIO  = 2'h2,
      MP_TACH  = 2'h3
   } ssp_mp_e;
endpackage

// *** ssp_link_if.sv ***
`timescale 1ns/10ps
interface ssp_link_if;
   logic frame_clr_n;
   logic [7:0] rx_byte;
   logic byte_tgl;
   logic ack_tgl;
   logic ack_bit;

   modport core (output frame_clr_n, input rx_byte, input byte_tgl, input ack_tgl, input ack_bit);
   modport link (input frame_clr_n, output rx_byte, output byte_tgl, output ack_tgl, output ack_bit);
endinterface

// *** ssp_link_rx.sv ***
`timescale 1ns/10ps
`include "ssp_cfg.svh"
module ssp_link_rx (
   // bus pins, raw
   input wire logic i_scl,
   input wire logic i_sda,
   // system reset
   input wire logic i_arst_n,
   // towards the core
   ssp_link_if.link lk
);
   logic [3:0] bit_cnt_reg;
   logic [6:0] shift_reg;
   logic [7:0] rx_reg;
   logic byte_tgl_reg;
   logic ack_tgl_reg;
   logic ack_bit_reg;

   // ----------------------------------------
   // bit framing on the bus clock
   // ----------------------------------------
   // nine pulses per byte, msb first; the core holds frame_clr_n low across start and stop
   always_ff @(posedge i_scl or negedge lk.frame_clr_n) begin
      if (!lk.frame_clr_n) begin
         bit_cnt_reg <= 4'h0;
         shift_reg <= 7'h00;
      end else if (bit_cnt_reg == `SSP_ACK_BIT) begin
         bit_cnt_reg <= 4'h0;
      end else begin
         shift_reg <= {shift_reg[5:0], i_sda};
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
   end

   // toggles only see the system reset, so a frame clear never fakes an event in the core
   always_ff @(posedge i_scl or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_reg <= 8'h00;
         byte_tgl_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
         ack_bit_reg <= 1'b1;
      end else if (lk.frame_clr_n) begin
         if (bit_cnt_reg == `SSP_LAST_DATA_BIT) begin
            rx_reg <= {shift_reg, i_sda};
            byte_tgl_reg <= ~byte_tgl_reg;
         end else if (bit_cnt_reg == `SSP_ACK_BIT) begin
            ack_bit_reg <= i_sda;
            ack_tgl_reg <= ~ack_tgl_reg;
         end
      end
   end

   // rx_byte stays put for a whole byte time after its toggle, which qualifies it in the core
   assign lk.rx_byte = rx_reg;
   assign lk.byte_tgl = byte_tgl_reg;
   assign lk.ack_tgl = ack_tgl_reg;
   assign lk.ack_bit = ack_bit_reg;
endmodule

// *** ssp_master_model.sv ***
`timescale 1ns/10ps
// smbus host model; o_sda_low pulls the pulled-up data wire down
module ssp_master_model (
   // bus wires
   output logic o_scl,
   output logic o_sda_low,
   input wire logic i_sda
);
   localparam real q = 31.25; // quarter of the 125 ns bus clock period
   // clock stands still high outside frames
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // start or repeated start: data falls while clock is high
   task start();
      o_sda_low = 1'b0;
      #q o_scl = 1'b1;
      #q o_sda_low = 1'b1;
      #q o_scl = 1'b0;
   endtask
   // one clock pulse; data moves only in the low half
   task pulse(input logic b, output logic r);
      #q o_sda_low = ~b;
      #q o_scl = 1'b1;
      #q r = i_sda;
      #q o_scl = 1'b0;
   endtask
   // eight bits, msb first
   task put8(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) pulse(d[i], r);
   endtask
   // byte plus the slot where the device acknowledges
   task send(input logic [7:0] d, output logic ack);
      logic r;
      put8(d);
      pulse(1'b1, r);
      ack = ~r;
   endtask
   // one byte read, always closed with no acknowledge
   task recv(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) pulse(1'b1, d[i]);
      pulse(1'b1, r);
   endtask
   // stop: data rises while clock is high
   task stop();
      #q o_sda_low = 1'b1;
      #q o_scl = 1'b1;
      #q o_sda_low = 1'b0;
      #q;
   endtask
endmodule

// *** test_smbus_slave_register_port.sv ***
`timescale 1ns/10ps
module test_smbus_slave_register_port;
   // ----------------------------------------
   // pins and bookkeeping
   // ----------------------------------------
   logic i_core_clk, i_arst_n, i_alert_cond, mp_lvl, ack, pin_req;
   logic [7:0] last_wdata, rd_d;
   wire scl, sda_low, sda_oe, mp_oe, ext_wr, alert_act, tlim, tach, gpio, sda_out, mp_out;
   wire [7:0] ptr, wdata;
   int failures = 0, n_tests = 0, n_wr = 0;
   // rival alert responder with a lower address
   localparam logic [7:0] RIVAL = 8'h4f;
   wire sda = ~sda_low & ~sda_oe; // pull-up wire, both sides open drain
   // short timeout so the idle test stays brief
   ssp_top #(.TIMEOUT_CYC(2000)) i_ssp_top (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_scl(scl),
      .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_mp_pin(mp_lvl & ~mp_oe),
      .o_mp_out(mp_out), .o_mp_oe(mp_oe),
      .i_alert_cond(i_alert_cond), .i_tlimit_assert(pin_req), .i_gpio_value(~pin_req), .i_gpio_dir(pin_req),
      .o_alert_active(alert_act), .o_thermal_limit_pin(tlim), .o_fourth_tach_input(tach), .o_gpio_in(gpio),
      .o_ptr(ptr), .o_ext_wr(ext_wr), .o_ext_wdata(wdata), .i_ext_rdata(ptr ^ 8'h3c));
   ssp_master_model i_ssp_master_model (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
   initial begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end
   // record writes that leave for the outside registers
   always @(posedge i_core_clk) if (ext_wr === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wdata <= wdata;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // sample a little after the edge so register updates have landed
   task cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task wr(input logic [7:0] cmd, input logic [7:0] dat);
      i_ssp_master_model.start();
      i_ssp_master_model.send(8'h5c, ack);
      check({7'h0, ack}, 8'h01);
      i_ssp_master_model.send(cmd, ack);
      check({7'h0, ack}, 8'h01);
      i_ssp_master_model.send(dat, ack);
      check({7'h0, ack}, 8'h01);
      i_ssp_master_model.stop();
   endtask
   task rd(input logic [7:0] a, input logic ok, input logic [7:0] exp);
      i_ssp_master_model.start();
      i_ssp_master_model.send(a, ack);
      check({7'h0, ack}, {7'h0, ok});
      if (ack === 1'b1) begin
         i_ssp_master_model.recv(rd_d);
         check(rd_d, exp);
      end
      i_ssp_master_model.stop();
   endtask
   task results();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset();
      check(ptr, 8'h00);
      check({2'h0, sda_out, mp_out, sda_oe, mp_oe, ext_wr, alert_act}, 8'h00);
      $display("t_reset done");
   endtask
   task t_write();
      wr(8'h12, 8'ha5);
      cyc(4);
      check(ptr, 8'h12);
      check(n_wr[7:0], 8'h01);
      check(last_wdata, 8'ha5);
      rd(8'h5d, 1'b1, 8'h12 ^ 8'h3c);
      $display("t_write done");
   endtask
   // send byte then repeated start read, then every pin function
   task t_pin();
      i_ssp_master_model.start();
      i_ssp_master_model.send(8'h5c, ack);
      i_ssp_master_model.send(8'h7d, ack);
      rd(8'h5d, 1'b1, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr(8'h7d, k[7:0]);
         @(posedge i_core_clk) mp_lvl <= 1'b1;
         cyc(6);
         check({6'h0, tach, gpio}, {6'h0, k == 3, k == 2});
         @(posedge i_core_clk) mp_lvl <= 1'b0;
         cyc(6);
         check({7'h0, tlim}, {7'h0, k == 1});
         // ask for a low pin: only the thermal and gpio functions may pull it
         @(posedge i_core_clk) pin_req <= 1'b1;
         cyc(4);
         check({7'h0, mp_oe}, {7'h0, k == 1 || k == 2});
         @(posedge i_core_clk) pin_req <= 1'b0;
      end
      check(n_wr[7:0], 8'h01);
      rd(8'h5d, 1'b1, 8'h03);
      $display("t_pin done");
   endtask
   task t_foreign();
      rd(8'h5e, 1'b0, 8'h00);
      rd(8'h5f, 1'b0, 8'h00);
      $display("t_foreign done");
   endtask
   // alert response: refused outside alert mode, kept while cause remains
   task t_ara();
      @(posedge i_core_clk) i_alert_cond <= 1'b1;
      cyc(4);
      rd(8'h19, 1'b0, 8'h00);
      wr(8'h7d, 8'h00);
      cyc(4);
      check({6'h0, alert_act, mp_oe}, 8'h03);
      rd(8'h19, 1'b1, 8'h5c);
      check({7'h0, alert_act}, 8'h01);
      // a rival answers too; once outvoted the device must let go of the line
      i_ssp_master_model.start();
      i_ssp_master_model.send(8'h19, ack);
      check({7'h0, ack}, 8'h01);
      for (int i = 7; i >= 0; i--) i_ssp_master_model.pulse(RIVAL[i], rd_d[i]);
      i_ssp_master_model.pulse(1'b1, ack);
      i_ssp_master_model.stop();
      check(rd_d, 8'h4f);
      @(posedge i_core_clk) i_alert_cond <= 1'b0;
      cyc(4);
      rd(8'h19, 1'b1, 8'h5c);
      cyc(4);
      check({6'h0, alert_act, mp_oe}, 8'h00);
      rd(8'h19, 1'b0, 8'h00);
      $display("t_ara done");
   endtask
   // clock held low mid-frame while the device drives its acknowledge
   task t_timeout();
      for (int k = 0; k < 2; k++) begin
         i_ssp_master_model.start();
         i_ssp_master_model.put8(8'h5c);
         cyc(10);
         check({7'h0, sda_oe}, 8'h01);
         cyc(2100);
         check({7'h0, sda_oe}, {7'h0, k == 1});
         i_ssp_master_model.pulse(1'b1, ack);
         i_ssp_master_model.stop();
         wr(8'h40, 8'h40);
      end
      $display("t_timeout done");
   endtask
   initial begin
      i_arst_n = 1'b0;
      i_alert_cond = 1'b0;
      pin_req = 1'b0;
      mp_lvl = 1'b1;
      repeat (20) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      cyc(8);
      t_reset();
      t_write();
      t_pin();
      t_foreign();
      t_ara();
      t_timeout();
      results();
   end
   // watchdog, well past the expected run of about 76 us
   initial begin
      #200000;
      failures++;
      results();
   end
endmodule
